// ---- atc_consts.svh ----
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_BAND 8'h04
`define REG_LIMIT 8'h08
`define REG_GAIN 8'h0C
`define REG_LOOP 8'h10
`define REG_STATUS 8'h14
`define REG_IRQ_STAT 8'h18
`define REG_IRQ_MASK 8'h1C
`define REG_LCONST 8'h20
`define REG_LSCALED 8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_EN 0
`define F_VS 1
`define F_LO8 7:0
`define F_HI8 15:8
`define F_DGAIN 11:8
`define F_DISC 15:12
`define F_AVG 2:0
`define F_HOLD 6:4
`define F_OVF 16
`define F_UNF 17
`define F_LC 10:0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RST_BAND 8'h00
`define RST_FLOOR 8'h00
`define RST_CEIL 8'hFF
`define RST_PGAIN 8'h01
`define RST_DGAIN 4'h0
`define RST_DISC 4'h0
`define RST_AVG 3'h0
`define RST_HOLD 3'h1
`define RST_THR 8'h00
`define RST_CMD 8'h80
`define AVG_2 3'b010
`define AVG_4 3'b100
`define AVG_8 3'b111
`define HOLD_MAX 3'h7

`endif

// ---- atc_pkg.sv ----
package atc_pkg;
  // Sequencer of one half-cycle evaluation
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_AVG = 2'b01,
    ST_EVAL = 2'b11
  } loop_state_t;
  typedef logic [7:0] level_t;
endpackage : atc_pkg

// ---- load_adaptive_current_loop.sv ----
`timescale 1ns/1ps
`include "atc_consts.svh"
module load_adaptive_current_loop import atc_pkg::*; (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HALF_CYCLE,
  input wire logic [7:0] LOAD_SAMPLE,
  input wire logic [7:0] SUPPLY_LEVEL,
  output logic [7:0] CURRENT_CMD,
  output logic BAND_OVERFLOW,
  output logic BAND_UNDERFLOW,
  output logic IRQ
);

  // ----------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------
  logic rst_s1; // First reset stage
  logic rst_n; // Released reset
  logic hc_s1, hc_s2, hc_d; // Half-cycle strobe chain
  logic [7:0] load_s1, load_s2; // Load sample sync
  logic [7:0] sup_s1, sup_s2; // Supply level sync
  logic hc_rise; // Start of half-cycle

  // Reset asserts at once, releases after two edges
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Two flops per pin; multi-bit inputs must be quasi-static
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      hc_s1 <= 1'b0;
      hc_s2 <= 1'b0;
      hc_d <= 1'b0;
      load_s1 <= 8'h00;
      load_s2 <= 8'h00;
      sup_s1 <= 8'h00;
      sup_s2 <= 8'h00;
    end else if (CE) begin
      hc_s1 <= HALF_CYCLE;
      hc_s2 <= hc_s1;
      hc_d <= hc_s2;
      load_s1 <= LOAD_SAMPLE;
      load_s2 <= load_s1;
      sup_s1 <= SUPPLY_LEVEL;
      sup_s2 <= sup_s1;
    end
  end

  assign hc_rise = hc_s2 & ~hc_d;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic en, vs; // Loop enable, supply scaling
  level_t upper, lower; // Band limits
  level_t floor_lim, ceil_lim; // Current limits
  level_t proportional_gain; // Proportional gain
  logic [3:0] derivative_gain; // Derivative gain
  logic [3:0] disc; // Error LSBs dropped
  logic [2:0] avg; // Averaging code
  logic [2:0] hold; // Half-cycles between changes
  level_t thr; // Derivative threshold
  logic [10:0] lconst; // Learned load constant
  logic [1:0] irq_stat, irq_mask; // Sticky events, mask
  logic wr_take; // Write completes now

  // Write lands at the edge where the master sees pready
  assign wr_take = PSEL & PENABLE & PWRITE & PREADY;

  // Software-owned fields
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      en <= 1'b0;
      vs <= 1'b0;
      upper <= `RST_BAND;
      lower <= `RST_BAND;
      floor_lim <= `RST_FLOOR;
      ceil_lim <= `RST_CEIL;
      proportional_gain <= `RST_PGAIN;
      derivative_gain <= `RST_DGAIN;
      disc <= `RST_DISC;
      avg <= `RST_AVG;
      hold <= `RST_HOLD;
      thr <= `RST_THR;
      lconst <= 11'h000;
      irq_mask <= 2'h0;
    end else if (CE && wr_take) begin
      if (PADDR == `REG_CTRL) begin
        en <= PWDATA[`F_EN];
        vs <= PWDATA[`F_VS];
      end else if (PADDR == `REG_BAND) begin
        upper <= PWDATA[`F_LO8];
        lower <= PWDATA[`F_HI8];
      end else if (PADDR == `REG_LIMIT) begin
        floor_lim <= PWDATA[`F_LO8];
        ceil_lim <= PWDATA[`F_HI8];
      end else if (PADDR == `REG_GAIN) begin
        proportional_gain <= PWDATA[`F_LO8];
        derivative_gain <= PWDATA[`F_DGAIN];
        disc <= PWDATA[`F_DISC];
      end else if (PADDR == `REG_LOOP) begin
        avg <= PWDATA[`F_AVG];
        hold <= PWDATA[`F_HOLD];
        thr <= PWDATA[`F_HI8];
      end else if (PADDR == `REG_IRQ_MASK) begin
        irq_mask <= PWDATA[1:0];
      end else if (PADDR == `REG_LCONST) begin
        lconst <= PWDATA[`F_LC];
      end
    end
  end

  // ----------------------------------------
  // Load count averaging
  // ----------------------------------------
  level_t hist [0:7]; // Last eight samples
  logic [10:0] psum [0:7]; // Running partial sums
  level_t count_sel; // Averaged count, combinational
  level_t load_count; // Count of this half-cycle

  // Shift history and build partial sums per entry
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_hist
      always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          hist[gi] <= 8'h00;
        end else if (CE && hc_rise) begin
          hist[gi] <= (gi == 0) ? load_s2 : hist[(gi == 0) ? 0 : gi - 1];
        end
      end
      if (gi == 0) begin : g_first
        assign psum[gi] = {3'h0, hist[gi]};
      end else begin : g_rest
        assign psum[gi] = psum[gi - 1] + {3'h0, hist[gi]};
      end
    end
  endgenerate

  // Average length picked by code; codes other than 2, 4 and 7 pass raw
  always_comb begin
    if (avg == `AVG_2) begin
      count_sel = psum[1][8:1];
    end else if (avg == `AVG_4) begin
      count_sel = psum[3][9:2];
    end else if (avg == `AVG_8) begin
      count_sel = psum[7][10:3];
    end else begin
      count_sel = hist[0];
    end
  end

  // ----------------------------------------
  // Supply scaling
  // ----------------------------------------
  level_t sup_ref; // Supply when scaling armed
  logic signed [8:0] delta; // Supply drift
  logic signed [9:0] up_sum; // Shifted upper limit
  level_t eff_upper; // Upper limit in use
  logic signed [11:0] lc_sum; // Shifted constant
  logic [10:0] lc_scaled; // Constant in use

  // Reference follows supply until scaling is switched on
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sup_ref <= 8'h00;
    end else if (CE && !vs) begin
      sup_ref <= sup_s2;
    end
  end

  // Offset tracking; upper limit saturated, constant forced to zero when the sum sets bit 11; cheaper than a divider
  always_comb begin
    delta = $signed({1'b0, sup_s2}) - $signed({1'b0, sup_ref});
    up_sum = $signed({2'h0, upper}) + {delta[8], delta};
    lc_sum = $signed({1'b0, lconst}) + {{3{delta[8]}}, delta};
    if (!vs) begin
      eff_upper = upper;
      lc_scaled = lconst;
    end else begin
      eff_upper = up_sum[9] ? 8'h00 : (up_sum[8] ? 8'hFF : up_sum[7:0]);
      lc_scaled = lc_sum[11] ? 11'h000 : lc_sum[10:0];
    end
  end

  // ----------------------------------------
  // PD correction
  // ----------------------------------------
  loop_state_t st; // Evaluation sequencer
  level_t lim_lo; // Floor, never above ceiling
  logic over, under; // Count outside band
  logic signed [8:0] err_raw, err, prev_err; // Error terms
  logic signed [9:0] de, de_mag; // Error change
  logic use_d; // Derivative active
  logic signed [17:0] pterm; // Proportional product
  logic signed [14:0] dterm; // Derivative product
  logic signed [18:0] u, adj; // Correction, steered
  logic signed [19:0] s; // Unclamped command
  level_t next_cmd; // Clamped command
  logic [2:0] hold_eff, hold_cnt; // Gap setting, counter
  logic hold_ok, apply; // Change allowed, taken
  level_t cmd; // Current command

  // Ceiling wins if limits are programmed crossed
  assign lim_lo = (floor_lim > ceil_lim) ? ceil_lim : floor_lim;
  assign over = load_count > eff_upper;
  assign under = !over && (load_count < lower);
  assign hold_eff = (hold == 3'h0) ? 3'h1 : hold;
  assign hold_ok = ({1'b0, hold_cnt} + 4'h1) >= {1'b0, hold_eff};

  always_comb begin
    // Signed distance past the crossed limit
    if (over) begin
      err_raw = $signed({1'b0, load_count}) - $signed({1'b0, eff_upper});
    end else if (under) begin
      err_raw = $signed({1'b0, load_count}) - $signed({1'b0, lower});
    end else begin
      err_raw = 9'sh000;
    end
    err = err_raw >>> disc;
    de = {err[8], err} - {prev_err[8], prev_err};
    de_mag = de[9] ? -de : de;
    use_d = de_mag > $signed({2'h0, thr});
    pterm = $signed({1'b0, proportional_gain}) * err;
    dterm = $signed({1'b0, derivative_gain}) * de;
    u = {pterm[17], pterm} + (use_d ? {{4{dterm[14]}}, dterm} : 19'sh00000);
    // Never move against the band side that was crossed
    if (over) begin
      adj = (u > 19'sh00000) ? u : 19'sh00001;
    end else begin
      adj = (u < 19'sh00000) ? u : -19'sh00001;
    end
    s = $signed({12'h000, cmd}) + {adj[18], adj};
    if (s > $signed({12'h000, ceil_lim})) begin
      next_cmd = ceil_lim;
    end else if (s < $signed({12'h000, lim_lo})) begin
      next_cmd = lim_lo;
    end else begin
      next_cmd = s[7:0];
    end
  end

  // Changes only when outside band and gap elapsed
  assign apply = (st == ST_EVAL) && en && (err != 9'sh000) && hold_ok;

  // One pass per half-cycle: shift, average, evaluate
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_IDLE;
    end else if (CE) begin
      case (st)
        ST_IDLE: st <= hc_rise ? ST_AVG : ST_IDLE;
        ST_AVG: st <= ST_EVAL;
        ST_EVAL: st <= ST_IDLE;
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Count latched once per half-cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      load_count <= 8'h00;
    end else if (CE && st == ST_AVG) begin
      load_count <= count_sel;
    end
  end

  // Previous error and gap counter
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      prev_err <= 9'sh000;
      hold_cnt <= 3'h0;
    end else if (CE && st == ST_EVAL) begin
      prev_err <= err;
      if (apply) begin
        hold_cnt <= 3'h0;
      end else if (hold_cnt != `HOLD_MAX) begin
        hold_cnt <= hold_cnt + 3'h1;
      end
    end
  end

  // Command: full ceiling when off, kept inside limits when on
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= `RST_CMD;
    end else if (CE) begin
      if (!en) begin
        cmd <= ceil_lim;
      end else if (apply) begin
        cmd <= next_cmd;
      end else if (cmd > ceil_lim) begin
        cmd <= ceil_lim;
      end else if (cmd < lim_lo) begin
        cmd <= lim_lo;
      end
    end
  end

  // ----------------------------------------
  // Flags and interrupt
  // ----------------------------------------
  // Band flags reflect the latest evaluation
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      BAND_OVERFLOW <= 1'b0;
      BAND_UNDERFLOW <= 1'b0;
    end else if (CE && st == ST_EVAL) begin
      BAND_OVERFLOW <= over;
      BAND_UNDERFLOW <= under;
    end
  end

  // Sticky events, write one to clear; a new event wins
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 2'h0;
    end else if (CE) begin
      irq_stat <= (irq_stat & ~((wr_take && PADDR == `REG_IRQ_STAT) ? PWDATA[1:0] : 2'h0))
                  | ((st == ST_EVAL) ? {under, over} : 2'h0);
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ <= 1'b0;
      CURRENT_CMD <= `RST_CMD;
    end else if (CE) begin
      IRQ <= |(irq_stat & irq_mask);
      CURRENT_CMD <= cmd;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [31:0] next_rdata; // Read mux
  logic next_err; // Unmapped address

  // Decode; unmapped or misaligned answers with an error
  always_comb begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (PADDR == `REG_CTRL) begin
      next_rdata = {30'h00000000, vs, en};
    end else if (PADDR == `REG_BAND) begin
      next_rdata = {16'h0000, lower, upper};
    end else if (PADDR == `REG_LIMIT) begin
      next_rdata = {16'h0000, ceil_lim, floor_lim};
    end else if (PADDR == `REG_GAIN) begin
      next_rdata = {16'h0000, disc, derivative_gain, proportional_gain};
    end else if (PADDR == `REG_LOOP) begin
      next_rdata = {16'h0000, thr, 1'b0, hold, 1'b0, avg};
    end else if (PADDR == `REG_STATUS) begin
      next_rdata = {14'h0000, BAND_UNDERFLOW, BAND_OVERFLOW, load_count, cmd};
    end else if (PADDR == `REG_IRQ_STAT) begin
      next_rdata = {30'h00000000, irq_stat};
    end else if (PADDR == `REG_IRQ_MASK) begin
      next_rdata = {30'h00000000, irq_mask};
    end else if (PADDR == `REG_LCONST) begin
      next_rdata = {21'h000000, lconst};
    end else if (PADDR == `REG_LSCALED) begin
      next_rdata = {21'h000000, lc_scaled};
    end else begin
      next_err = 1'b1;
    end
  end

  // One wait state: ready in the second access cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
        PSLVERR <= next_err;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  a_cmd_in_limits: assert property (en && $past(en) && CE && $past(CE) && $stable(floor_lim)
    && $stable(ceil_lim) && floor_lim <= ceil_lim |-> cmd >= floor_lim && cmd <= ceil_lim)
    else $error("command outside limits");
  a_ovf_flag: assert property (st == ST_EVAL && CE && load_count > eff_upper |=> BAND_OVERFLOW)
    else $error("overflow flag missing");
  a_unf_flag: assert property (st == ST_EVAL && CE && load_count < lower && load_count <= eff_upper
    |=> BAND_UNDERFLOW)
    else $error("underflow flag missing");
  a_raise_on_over: assert property (apply && CE && over && cmd < ceil_lim && floor_lim <= ceil_lim
    |=> cmd > $past(cmd))
    else $error("current not raised");
  a_lower_on_under: assert property (apply && CE && under && cmd > floor_lim && floor_lim <= ceil_lim
    |=> cmd < $past(cmd))
    else $error("current not lowered");
  a_avg_two: assert property (st == ST_AVG && CE && avg == `AVG_2
    |=> load_count == $past(psum[1][8:1]))
    else $error("two-sample average wrong");
  a_hold_gap: assert property (apply && CE && hold == `HOLD_MAX && $stable(hold)
    |=> !apply [*8])
    else $error("change before hold delay");
  a_no_deriv: assert property (st == ST_EVAL && !use_d |-> u == {pterm[17], pterm})
    else $error("derivative used below threshold");
  a_trunc_all: assert property (st == ST_EVAL && disc == 4'hF && !under |-> err == 9'sh000)
    else $error("truncation ignored");
  a_zero_in_band: assert property (st == ST_EVAL && !over && !under |-> err == 9'sh000 && !apply)
    else $error("error nonzero inside band");
  a_eval_paced: assert property (st == ST_EVAL |-> $past(st) == ST_AVG && $past(st, 2) == ST_IDLE)
    else $error("evaluation out of sequence");

endmodule : load_adaptive_current_loop

// ---- load_adaptive_current_loop_bench.sv ----
`timescale 1ns/1ps
`include "atc_consts.svh"
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module load_adaptive_current_loop_bench import atc_pkg::*;;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic hcl, ovf, unf, irq, go, slow, ce;
  level_t ld_sample, supply, cmd, ld;
  int n_errors, num_checks;
  logic [31:0] rd; // Last read data
  logic er; // Last error response

  load_adaptive_current_loop uut (.CLK(clk), .NRST(nrst), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .HALF_CYCLE(hcl), .LOAD_SAMPLE(ld_sample), .SUPPLY_LEVEL(supply),
    .CURRENT_CMD(cmd), .BAND_OVERFLOW(ovf), .BAND_UNDERFLOW(unf), .IRQ(irq));
  motor_load_model motor (.clk(clk), .go(go), .slow(slow), .load(ld), .half_cycle(hcl),
    .load_sample(ld_sample));

  // ----------------------------------------
  // Bus and half-cycle helpers
  // ----------------------------------------
  // One full transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", ex, rd)
  endtask : rchk

  // One half-cycle at a given load, then judge command and flags
  task automatic hc(input level_t l, input level_t ec, input logic eo, input logic eu);
    int i;
    @(posedge clk);
    go <= 1'b1;
    ld <= l;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 40 && hcl !== 1'b1; i++) @(posedge clk);
    // Evaluation lands a fixed few edges after the synchronised rise
    repeat (10) @(posedge clk);
    `CHK("current_cmd", ec, cmd)
    `CHK("band_overflow", eo, ovf)
    `CHK("band_underflow", eu, unf)
  endtask : hc

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0] ra [4] = '{`REG_BAND, `REG_LIMIT, `REG_GAIN, `REG_LOOP};
    logic [31:0] rv [4] = '{32'h0, 32'h0000FF00, 32'h00000001, 32'h00000010};
    logic [31:0] wv [4] = '{32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0000FF77};
    foreach (ra[i]) rchk(ra[i], rv[i]);
    // Bits above each field read as zero
    foreach (ra[i]) begin
      apb(1'b1, ra[i], 32'hFFFFFFFF);
      rchk(ra[i], wv[i]);
    end
    // Unmapped and misaligned places are refused
    apb(1'b0, 8'h28, 32'h0);
    `CHK("pslverr", 1'b1, er)
    `CHK("prdata", 32'h0, rd)
    apb(1'b1, 8'h06, 32'h1);
    `CHK("pslverr", 1'b1, er)
  endtask : t_regs

  task automatic t_setup;
    apb(1'b1, `REG_LIMIT, 32'h0000F010);
    apb(1'b1, `REG_BAND, 32'h0000080A);
    apb(1'b1, `REG_GAIN, 32'h00000001);
    apb(1'b1, `REG_LOOP, 32'h00000010);
    repeat (4) @(posedge clk);
    `CHK("current_cmd", 8'hF0, cmd)
    apb(1'b1, `REG_CTRL, 32'h1);
  endtask : t_setup

  task automatic t_loop;
    hc(8'd4, 8'hEC, 1'b0, 1'b1);
    hc(8'd9, 8'hEC, 1'b0, 1'b0);
    hc(8'd13, 8'hEF, 1'b1, 1'b0);
    apb(1'b1, `REG_GAIN, 32'h00000201);
    apb(1'b1, `REG_LOOP, 32'h00000510);
    hc(8'd0, 8'hD1, 1'b0, 1'b1);
    hc(8'd1, 8'hCA, 1'b0, 1'b1);
    apb(1'b1, `REG_GAIN, 32'h00001201);
    hc(8'd4, 8'hC8, 1'b0, 1'b1);
    apb(1'b1, `REG_GAIN, 32'h000012FF);
    hc(8'd0, 8'h10, 1'b0, 1'b1);
  endtask : t_loop

  // Codes 2, 4, 7 and raw code 1, window contents known from history
  task automatic t_avg;
    apb(1'b1, `REG_GAIN, 32'h00000001);
    apb(1'b1, `REG_LOOP, 32'h00000012);
    hc(8'd30, 8'h15, 1'b1, 1'b0);
    rchk(`REG_STATUS, 32'h00010F15);
    hc(8'd30, 8'h29, 1'b1, 1'b0);
    apb(1'b1, `REG_LOOP, 32'h00000014);
    hc(8'd30, 8'h35, 1'b1, 1'b0);
    apb(1'b1, `REG_LOOP, 32'h00000017);
    hc(8'd30, 8'h3A, 1'b1, 1'b0);
    apb(1'b1, `REG_LOOP, 32'h00000011);
    hc(8'd30, 8'h4E, 1'b1, 1'b0);
  endtask : t_avg

  // Longest legal gap between changes, slow motor
  task automatic t_hold;
    apb(1'b1, `REG_LOOP, 32'h00000070);
    slow <= 1'b1;
    repeat (6) hc(8'd20, 8'h4E, 1'b1, 1'b0);
    hc(8'd20, 8'h58, 1'b1, 1'b0);
    slow <= 1'b0;
  endtask : t_hold

  task automatic t_irq;
    `CHK("irq", 1'b0, irq)
    rchk(`REG_IRQ_STAT, 32'h3);
    apb(1'b1, `REG_IRQ_MASK, 32'h1);
    // Clock enable low freezes the interrupt output
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, `REG_IRQ_STAT, 32'h3);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    rchk(`REG_IRQ_STAT, 32'h0);
    apb(1'b1, `REG_IRQ_MASK, 32'h2);
    hc(8'd0, 8'h58, 1'b0, 1'b1);
    `CHK("irq", 1'b1, irq)
  endtask : t_irq

  // Scaling switched on only after the band is set
  task automatic t_scale;
    apb(1'b1, `REG_LOOP, 32'h00000010);
    apb(1'b1, `REG_LCONST, 32'h00000100);
    apb(1'b1, `REG_CTRL, 32'h3);
    supply <= 8'd110;
    repeat (8) @(posedge clk);
    rchk(`REG_LSCALED, 32'h0000010A);
    hc(8'd15, 8'h58, 1'b0, 1'b0);
  endtask : t_scale

  // ----------------------------------------
  // Clock, run and verdict
  // ----------------------------------------
  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim;
  end

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    go = 1'b0;
    slow = 1'b0;
    ce = 1'b1;
    ld = 8'h00;
    supply = 8'd100;
    n_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    // Internal reset copy needs a few edges to release
    repeat (3) @(posedge clk);
    t_regs;
    t_setup;
    t_loop;
    t_avg;
    t_hold;
    t_irq;
    t_scale;
    end_sim;
  end
endmodule : load_adaptive_current_loop_bench

// ---- motor_load_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Motor side: half-cycle edges and load measure
// ----------------------------------------
module motor_load_model (
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire logic [7:0] load,
  output logic half_cycle,
  output logic [7:0] load_sample
);
  // One electrical half-cycle per request
  // The load measure settles well before the edge, so the block's sampler never sees it move
  initial begin
    half_cycle = 1'b0;
    load_sample = 8'h00;
    forever begin
      @(posedge clk);
      if (go) begin
        load_sample <= load;
        // Slow motor: longer quiet time before the edge
        repeat (slow ? 9 : 4) @(posedge clk);
        half_cycle <= 1'b1;
        // Held high long enough for the synchroniser
        repeat (4) @(posedge clk);
        half_cycle <= 1'b0;
      end
    end
  end
endmodule : motor_load_model
